// *** scr_defs.svh ***
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// ----------------------------------------
// clock and divider figures
// ----------------------------------------
`define SCR_CLK_NS        25
`define SCR_DIV           10'd586
`define SCR_DIV_HALF      10'd293
`define SCR_SEC_CYC       17'h08000

// ----------------------------------------
// frequency tuning
// ----------------------------------------
// one cycle per ten-second block is one tuning step
`define SCR_TUNE_BLOCK    4'd10
`define SCR_TUNE_MAX      7'sd63
`define SCR_TUNE_MIN      -7'sd63

// ----------------------------------------
// low-frequency oscillator calibration
// ----------------------------------------
`define SCR_CAL_WIN       6'd63
`define SCR_CAL_EXP       16'd37504

// ----------------------------------------
// power-loss pause and oscillator watchdog
// ----------------------------------------
`define SCR_PAUSE_SEC     2'd3
`define SCR_OSC_STOP_NS   100000
`define SCR_OSC_STOP_CYC  (`SCR_OSC_STOP_NS / `SCR_CLK_NS)

`endif

// *** scr_pkg.sv ***
package scr_pkg;

	// ----------------------------------------
	// sleep clock source selection
	// ----------------------------------------
	typedef enum logic [1:0] {
		SCR_SRC_RCDIV = 2'b00,
		SCR_SRC_XODIV = 2'b01,
		SCR_SRC_LFOSC = 2'b10
	} scr_src_t;

endpackage : scr_pkg

// *** scr_div.sv ***
`timescale 1ns/1ps
`include "scr_defs.svh"

module scr_div (
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	input  wire logic i_src_tick,
	output logic      o_div_clk,
	output logic      o_div_rise
);

	// ----------------------------------------
	// fixed integer divider
	// ----------------------------------------
	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic       wrap;
	logic       half;

	// wrap and mid-point decode
	assign wrap    = i_src_tick && (cnt_r == `SCR_DIV - 10'd1);
	assign half    = i_src_tick && (cnt_r == `SCR_DIV_HALF - 10'd1);
	assign cnt_nxt = wrap ? 10'd0 : cnt_r + 10'd1;

	// count source edges
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			cnt_r <= 10'd0;
		else if (i_src_tick)
			cnt_r <= cnt_nxt;
	end

	// square output: low for first half, high for second
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_div_clk  <= 1'b0;
			o_div_rise <= 1'b0;
		end
		else
		begin
			o_div_clk  <= half ? 1'b1 : (wrap ? 1'b0 : o_div_clk);
			o_div_rise <= half;
		end
	end

endmodule : scr_div

// *** scr_rtc.sv ***
`timescale 1ns/1ps
`include "scr_defs.svh"

module scr_rtc (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_xo_tick,
	input  wire logic        i_rcosc_tick,
	input  wire logic        i_lfosc_clk,
	input  wire logic        i_xo_ok,
	input  wire logic        i_lfosc_ok,
	input  wire logic        i_sys_on,
	input  wire logic        i_sw_sel_xo,
	input  wire logic        i_gpio_route_en,
	input  wire logic        i_batt_present,
	input  wire logic        i_backup_cell_supply_low,
	input  wire logic        i_brief_power_loss_event,
	input  wire logic [6:0]  i_tune,
	input  wire logic        i_time_wr,
	input  wire logic [31:0] i_time_wdata,
	input  wire logic        i_alarm_wr,
	input  wire logic [31:0] i_alarm_wdata,
	input  wire logic        i_alarm_en,
	output logic             o_sleep_clk,
	output logic             o_gpio_sleep_clk,
	output logic [1:0]       o_src,
	output logic [31:0]      o_time,
	output logic [31:0]      o_alarm,
	output logic             o_time_valid,
	output logic             o_sec_tick,
	output logic             o_alarm_irq,
	output logic             o_rtc_reset_irq,
	output logic             o_osc_stop_irq,
	output logic [15:0]      o_lfosc_cal_err,
	output logic             o_lfosc_cal_done
);

	// ----------------------------------------
	// divided sources
	// ----------------------------------------
	logic xo_clk;
	logic xo_rise;
	logic rc_clk;
	logic rc_rise;

	scr_div u_xo_div (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_src_tick (i_xo_tick),
		.o_div_clk  (xo_clk),
		.o_div_rise (xo_rise)
	);

	scr_div u_rc_div (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_src_tick (i_rcosc_tick),
		.o_div_clk  (rc_clk),
		.o_div_rise (rc_rise)
	);

	// ----------------------------------------
	// source selection
	// ----------------------------------------
	scr_pkg::scr_src_t src_r;
	scr_pkg::scr_src_t src_nxt;
	logic              lf_d_r;
	logic              lf_rise;
	logic              sel_clk;
	logic              sel_rise;
	logic              use_xo;
	logic              use_lf;

	// while on without the software switch, rc stays selected
	assign use_xo  = i_sys_on && i_sw_sel_xo && i_xo_ok;
	// rc only as last resort once switched
	assign use_lf  = i_sys_on && i_sw_sel_xo && !i_xo_ok && i_lfosc_ok;
	// powered off always runs on low-freq osc
	assign src_nxt = !i_sys_on ? scr_pkg::SCR_SRC_LFOSC :
	                 use_xo    ? scr_pkg::SCR_SRC_XODIV :
	                 use_lf    ? scr_pkg::SCR_SRC_LFOSC :
	                             scr_pkg::SCR_SRC_RCDIV;

	// low-freq osc level edge, input is already synchronous
	assign lf_rise = i_lfosc_clk && !lf_d_r;

	// selected level feeds the clock outputs, selected edge the counter
	assign sel_clk  = (src_r == scr_pkg::SCR_SRC_XODIV) ? xo_clk :
	                  (src_r == scr_pkg::SCR_SRC_LFOSC) ? i_lfosc_clk :
	                                                      rc_clk;
	assign sel_rise = (src_r == scr_pkg::SCR_SRC_XODIV) ? xo_rise :
	                  (src_r == scr_pkg::SCR_SRC_LFOSC) ? lf_rise :
	                                                      rc_rise;

	// selection register, rc after reset
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			src_r  <= scr_pkg::SCR_SRC_RCDIV;
			lf_d_r <= 1'b0;
		end
		else
		begin
			src_r  <= src_nxt;
			lf_d_r <= i_lfosc_clk;
		end
	end

	// host and gpio copies; switching may stretch one phase
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_sleep_clk      <= 1'b0;
			o_gpio_sleep_clk <= 1'b0;
		end
		else
		begin
			o_sleep_clk      <= sel_clk;
			o_gpio_sleep_clk <= sel_clk && i_gpio_route_en;
		end
	end

	assign o_src = src_r;

	// ----------------------------------------
	// one-second prescaler with tuning
	// ----------------------------------------
	logic [15:0] sec_cnt_r;
	logic [3:0]  blk_r;
	logic [6:0]  tune_c;
	logic [16:0] sec_len;
	logic [15:0] sec_last;
	logic        sec_end;
	logic        blk_end;

	// clamp to +-63 steps, about +-192 ppm
	assign tune_c   = ($signed(i_tune) > `SCR_TUNE_MAX) ? `SCR_TUNE_MAX :
	                  ($signed(i_tune) < `SCR_TUNE_MIN) ? `SCR_TUNE_MIN :
	                  i_tune;
	// last second of the block absorbs the correction
	assign blk_end  = (blk_r == `SCR_TUNE_BLOCK - 4'd1);
	assign sec_len  = blk_end ? (`SCR_SEC_CYC - {{10{tune_c[6]}}, tune_c})
	                          : `SCR_SEC_CYC;
	assign sec_last = sec_len[15:0] - 16'd1;
	// tick on the last sleep cycle of the second
	assign sec_end  = sel_rise && (sec_cnt_r == sec_last);

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			sec_cnt_r <= 16'd0;
		else if (sec_end)
			sec_cnt_r <= 16'd0;
		else if (sel_rise)
			sec_cnt_r <= sec_cnt_r + 16'd1;
	end

	// tuning block position
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			blk_r <= 4'd0;
		else if (sec_end)
			blk_r <= blk_end ? 4'd0 : blk_r + 4'd1;
	end

	// ----------------------------------------
	// time, alarm and validity
	// ----------------------------------------
	logic [31:0] time_r;
	logic [31:0] alarm_r;
	logic [1:0]  pause_r;
	logic        valid_r;
	logic        coin_bad;
	logic        coin_bad_d_r;
	logic        coin_fall;
	logic        loss_evt;
	logic        invalidate;
	logic        advance;

	// backup collapse only counts without battery
	assign coin_bad   = !i_batt_present && i_backup_cell_supply_low;
	assign coin_fall  = coin_bad && !coin_bad_d_r;
	// power-loss event counts with battery present
	assign loss_evt   = i_brief_power_loss_event && i_batt_present;
	assign invalidate = loss_evt || coin_fall;
	// no dependency on i_sys_on, runs while off
	assign advance    = sec_end && (pause_r == 2'd0);

	// 32-bit time, software write wins over a tick
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			time_r <= 32'h0000_0000;
		else if (i_time_wr)
			time_r <= i_time_wdata;
		else if (advance)
			time_r <= time_r + 32'd1;
	end

	// pause a few seconds after the loss event
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			pause_r <= 2'd0;
		else if (loss_evt)
			pause_r <= `SCR_PAUSE_SEC;
		else if (i_time_wr)
			pause_r <= 2'd0;
		else if (sec_end && (pause_r != 2'd0))
			pause_r <= pause_r - 2'd1;
	end

	// invalidation beats a same-cycle software write
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			valid_r      <= 1'b0;
			coin_bad_d_r <= 1'b0;
		end
		else
		begin
			valid_r      <= invalidate ? 1'b0 : (i_time_wr | valid_r);
			coin_bad_d_r <= coin_bad;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			alarm_r <= 32'h0000_0000;
		else if (i_alarm_wr)
			alarm_r <= i_alarm_wdata;
	end

	assign o_time       = time_r;
	assign o_alarm      = alarm_r;
	assign o_time_valid = valid_r;

	// ----------------------------------------
	// event pulses
	// ----------------------------------------
	logic        hit;
	logic        hit_d_r;
	logic [11:0] stop_cnt_r;
	logic        stopped_r;
	logic        stop_now;

	assign hit      = i_alarm_en && (time_r == alarm_r);
	// watchdog sees no selected edge for too long
	assign stop_now = !sel_rise && !stopped_r &&
	                  (stop_cnt_r == 12'(`SCR_OSC_STOP_CYC - 1));

	// oscillator watchdog counter
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			stop_cnt_r <= 12'd0;
		else if (sel_rise)
			stop_cnt_r <= 12'd0;
		else if (!stopped_r && !stop_now)
			stop_cnt_r <= stop_cnt_r + 12'd1;
	end

	// stopped flag rearms on the next edge
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			stopped_r <= 1'b0;
		else if (sel_rise)
			stopped_r <= 1'b0;
		else if (stop_now)
			stopped_r <= 1'b1;
	end

	// registered one-cycle pulses
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			hit_d_r         <= 1'b0;
			o_alarm_irq     <= 1'b0;
			o_rtc_reset_irq <= 1'b0;
			o_osc_stop_irq  <= 1'b0;
			o_sec_tick      <= 1'b0;
		end
		else
		begin
			hit_d_r         <= hit;
			o_alarm_irq     <= hit && !hit_d_r;
			o_rtc_reset_irq <= invalidate;
			o_osc_stop_irq  <= stop_now;
			o_sec_tick      <= advance;
		end
	end

	// ----------------------------------------
	// low-freq oscillator calibration
	// ----------------------------------------
	logic [5:0]  cal_lf_r;
	logic [15:0] cal_xo_r;
	logic [15:0] cal_xo_inc;
	logic        cal_end;

	// count crystal ticks over 64 low-freq periods
	assign cal_xo_inc = cal_xo_r + {15'd0, i_xo_tick};
	assign cal_end    = i_xo_ok && lf_rise && (cal_lf_r == `SCR_CAL_WIN);

	// window counters restart when the crystal drops out
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cal_lf_r <= 6'd0;
			cal_xo_r <= 16'd0;
		end
		else if (!i_xo_ok || cal_end)
		begin
			cal_lf_r <= 6'd0;
			cal_xo_r <= 16'd0;
		end
		else
		begin
			cal_lf_r <= cal_lf_r + {5'd0, lf_rise};
			cal_xo_r <= cal_xo_inc;
		end
	end

	// error against nominal, positive means osc is slow
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_lfosc_cal_err  <= 16'h0000;
			o_lfosc_cal_done <= 1'b0;
		end
		else
		begin
			if (cal_end)
				o_lfosc_cal_err <= cal_xo_inc - `SCR_CAL_EXP;
			o_lfosc_cal_done <= cal_end;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_powerup_rc: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		(i_sys_on && !i_sw_sel_xo) |=> (o_src == 2'b00))
		else $error("rc not held before software switch");

	a_off_lfosc: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		!i_sys_on |=> (o_src == 2'b10))
		else $error("low-freq osc not selected while off");

	a_xo_chosen: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		(i_sys_on && i_sw_sel_xo && i_xo_ok) |=> (o_src == 2'b01))
		else $error("crystal source not taken");

	a_rc_fallback: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		(i_sys_on && i_sw_sel_xo && i_lfosc_ok) |=> (o_src != 2'b00))
		else $error("rc used while other source present");

	a_time_step: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		(advance && !i_time_wr) |=> (o_time == $past(o_time) + 32'd1)
		##0 o_sec_tick)
		else $error("time did not step on the second");

	a_loss_pause: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		loss_evt |=> (o_rtc_reset_irq && !o_time_valid
		&& pause_r == 2'd3))
		else $error("power-loss handling wrong");

	a_coin_reset: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		$rose(coin_bad) |=> (o_rtc_reset_irq && !o_time_valid))
		else $error("backup collapse not flagged");

	a_alarm_fire: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		(hit && !hit_d_r) |=> o_alarm_irq ##1 !o_alarm_irq)
		else $error("alarm pulse wrong");

	a_osc_stop: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		stop_now |=> (o_osc_stop_irq && stopped_r && !o_rtc_reset_irq
		|| o_osc_stop_irq && stopped_r))
		else $error("osc stop not reported");

	a_gpio_gate: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		!i_gpio_route_en |=> !o_gpio_sleep_clk)
		else $error("gpio sleep clock leaks when unrouted");

	a_tune_range: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		(sec_len >= 17'd32705) && (sec_len <= 17'd32831))
		else $error("tuned second out of range");

endmodule : scr_rtc

// *** scr_osc_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// source oscillators feeding the block
// ----------------------------------------
// crystal and fast rc arrive as tick pulses; the low-freq osc is a
// square wave that stands at its last level while its half period is 0
module scr_osc_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_xo_run,
	input  wire logic       i_rc_run,
	input  wire logic [7:0] i_lf_half,
	output logic            o_xo_tick,
	output logic            o_rc_tick,
	output logic            o_lf_clk
);
	logic [7:0] lf_cnt_r;

	initial
	begin
		o_xo_tick = 1'b0;
		o_rc_tick = 1'b0;
		o_lf_clk  = 1'b0;
		lf_cnt_r  = 8'h00;
	end

	// rc ticks every other cycle so a wrong divider path shows in the rate
	always @(posedge i_core_clk)
	begin
		o_xo_tick <= i_xo_run;
		o_rc_tick <= i_rc_run & ~o_rc_tick;
		if (i_lf_half == 8'h00)
			lf_cnt_r <= 8'h00;
		else if (lf_cnt_r >= i_lf_half - 8'h01)
		begin
			lf_cnt_r <= 8'h00;
			o_lf_clk <= ~o_lf_clk;
		end
		else
			lf_cnt_r <= lf_cnt_r + 8'h01;
	end
endmodule : scr_osc_model

// *** scr_rtc_tb.sv ***
`timescale 1ns/1ps

module scr_rtc_tb;
	logic        clk, nrst, xo_run, rc_run, xo_tk, rc_tk, lf_clk;
	logic        xo_ok, lf_ok, sys_on, sw_xo, gpio_en, batt, bk_low;
	logic        pl_evt, t_wr, a_wr, a_en;
	logic [7:0]  lf_half;
	logic [6:0]  tune;
	logic [31:0] t_wd, a_wd, o_time, o_alarm;
	logic [1:0]  o_src;
	logic [15:0] cal_err;
	logic        slp, gslp, valid, sec, a_irq, r_irq, s_irq, cal_done;
	int          failures, check_count, cycle_count;

	scr_osc_model i_scr_osc_model (.i_core_clk(clk), .i_xo_run(xo_run),
		.i_rc_run(rc_run), .i_lf_half(lf_half), .o_xo_tick(xo_tk),
		.o_rc_tick(rc_tk), .o_lf_clk(lf_clk));

	scr_rtc i_scr_rtc (.i_core_clk(clk), .i_nrst(nrst), .i_xo_tick(xo_tk),
		.i_rcosc_tick(rc_tk), .i_lfosc_clk(lf_clk), .i_xo_ok(xo_ok),
		.i_lfosc_ok(lf_ok), .i_sys_on(sys_on), .i_sw_sel_xo(sw_xo),
		.i_gpio_route_en(gpio_en), .i_batt_present(batt),
		.i_backup_cell_supply_low(bk_low),
		.i_brief_power_loss_event(pl_evt), .i_tune(tune),
		.i_time_wr(t_wr), .i_time_wdata(t_wd), .i_alarm_wr(a_wr),
		.i_alarm_wdata(a_wd), .i_alarm_en(a_en), .o_sleep_clk(slp),
		.o_gpio_sleep_clk(gslp), .o_src(o_src), .o_time(o_time),
		.o_alarm(o_alarm), .o_time_valid(valid), .o_sec_tick(sec),
		.o_alarm_irq(a_irq), .o_rtc_reset_irq(r_irq),
		.o_osc_stop_irq(s_irq), .o_lfosc_cal_err(cal_err),
		.o_lfosc_cal_done(cal_done));

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// whole run is about 86k cycles, so 100k means a hang
	always @(posedge clk)
	begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == 100000)
		begin
			failures = failures + 1;
			final_report();
		end
	end

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input bit alarm, input logic [31:0] d);
		@(posedge clk);
		t_wr <= ~alarm;
		a_wr <= alarm;
		t_wd <= d;
		a_wd <= d;
		@(posedge clk);
		t_wr <= 1'b0;
		a_wr <= 1'b0;
		#1;
	endtask : wr

	// cycles between two rising edges of the sleep clock output
	task automatic rise_gap(output int gap);
		int   k;
		int   first;
		logic prev;
		first = -1;
		gap = 0;
		prev = slp;
		for (k = 0; k < 5000 && gap == 0; k++)
		begin
			@(posedge clk);
			#1;
			if (slp === 1'b1 && prev === 1'b0 && first >= 0)
				gap = k - first;
			if (slp === 1'b1 && prev === 1'b0 && first < 0)
				first = k;
			prev = slp;
		end
	endtask : rise_gap

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_select;
		logic [5:0] tab [5] = '{6'b1011_00, 6'b1111_01, 6'b1101_10,
			6'b1100_00, 6'b0111_10};
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk);
			{sys_on, sw_xo, xo_ok, lf_ok} <= tab[i][5:2];
			repeat (2) @(posedge clk);
			#1;
			chk("source", {30'h0, tab[i][1:0]}, o_src);
		end
		$display("test select done");
	endtask : test_select

	task automatic test_divider;
		int g;
		@(posedge clk);
		{sys_on, sw_xo, xo_ok, lf_ok, gpio_en} <= 5'b11101;
		// let the source switch settle so its phase jump is not timed
		repeat (4) @(posedge clk);
		rise_gap(g);
		chk("crystal period", 32'd586, g);
		chk("gpio clock", 32'h1, gslp);
		@(posedge clk);
		gpio_en <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("gpio gated", 32'h0, gslp);
		@(posedge clk);
		sw_xo <= 1'b0;
		rc_run <= 1'b1;
		repeat (4) @(posedge clk);
		rise_gap(g);
		chk("rc period", 32'd1172, g);
		$display("test divider done");
	endtask : test_divider

	task automatic test_alarm;
		int n;
		wr(1'b0, 32'hdead_0001);
		chk("time", 32'hdead_0001, o_time);
		chk("valid", 32'h1, valid);
		a_en <= 1'b1;
		wr(1'b1, 32'hdead_0001);
		chk("alarm", 32'hdead_0001, o_alarm);
		n = 0;
		repeat (6)
		begin
			if (a_irq === 1'b1)
				n++;
			@(posedge clk);
			#1;
		end
		chk("alarm pulses", 32'h1, n);
		$display("test alarm done");
	endtask : test_alarm

	task automatic test_invalid;
		@(posedge clk);
		pl_evt <= 1'b1;
		@(posedge clk);
		pl_evt <= 1'b0;
		#1;
		chk("loss irq", 32'h1, r_irq);
		chk("loss valid", 32'h0, valid);
		wr(1'b0, 32'h0000_0100);
		chk("rewrite valid", 32'h1, valid);
		@(posedge clk);
		batt <= 1'b0;
		bk_low <= 1'b1;
		@(posedge clk);
		#1;
		chk("backup irq", 32'h1, r_irq);
		chk("backup valid", 32'h0, valid);
		@(posedge clk);
		batt <= 1'b1;
		bk_low <= 1'b0;
		$display("test invalid done");
	endtask : test_invalid

	task automatic test_stop;
		int n;
		int r;
		@(posedge clk);
		sys_on <= 1'b0;
		r = 0;
		for (n = 0; n < 4500 && s_irq !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
			r += (r_irq === 1'b1);
		end
		chk("stop irq", 32'h1, s_irq);
		chk("stop late", 32'h1, n > 2800);
		chk("no reset irq", 32'h0, r);
		$display("test stop done");
	endtask : test_stop

	task automatic test_cal;
		int n;
		int d;
		@(posedge clk);
		lf_half <= 8'd50;
		d = 0;
		for (n = 0; n < 20000 && d < 2; n++)
		begin
			@(posedge clk);
			#1;
			d += (cal_done === 1'b1);
		end
		// 64 periods of 100 crystal ticks against 37504 expected
		chk("cal error", 32'h1, cal_err === 16'h8680 ||
			cal_err === 16'h867f || cal_err === 16'h8681);
		$display("test cal done");
	endtask : test_cal

	task automatic test_second;
		int n;
		@(posedge clk);
		lf_half <= 8'd1;
		// out-of-range tuning code must be clamped by the design
		tune <= 7'h40;
		wr(1'b1, 32'h0000_1001);
		wr(1'b0, 32'h0000_1000);
		for (n = 0; n < 66000 && sec !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk("tick seen", 32'h1, sec);
		chk("tick bound", 32'h1, n <= 65540);
		chk("time step", 32'h0000_1001, o_time);
		@(posedge clk);
		#1;
		chk("tick alarm", 32'h1, a_irq);
		$display("test second done");
	endtask : test_second

	task automatic final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{nrst, xo_run, rc_run, xo_ok, lf_ok, sw_xo, gpio_en} = 7'b0100000;
		{bk_low, pl_evt, t_wr, a_wr, a_en} = 5'b00000;
		{sys_on, batt} = 2'b11;
		lf_half = 8'h00;
		tune = 7'h00;
		t_wd = 32'h0;
		a_wd = 32'h0;
		failures = 0;
		check_count = 0;
		cycle_count = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		chk("reset source", 32'h0, o_src);
		chk("reset valid", 32'h0, valid);
		test_select();
		test_divider();
		test_alarm();
		test_invalid();
		test_stop();
		test_cal();
		test_second();
		final_report();
	end
endmodule : scr_rtc_tb
